// ==== rtl/uir_pkg.sv ====
/*
  Package for one UART channel's optical codec, loopback and register decode.
  Assumes a 32-bit AHB-Lite bus and a 16x sampling enable from a baud generator outside.
*/
package uir_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] uir_idx_data = 4'h0;
  localparam logic [3:0] uir_idx_int_enable = 4'h1;
  localparam logic [3:0] uir_idx_int_status = 4'h2;
  localparam logic [3:0] uir_idx_line_format = 4'h3;
  localparam logic [3:0] uir_idx_modem_control = 4'h4;
  localparam logic [3:0] uir_idx_line_state = 4'h5;
  localparam logic [3:0] uir_idx_modem_state = 4'h6;
  localparam logic [3:0] uir_idx_scratch = 4'h7;
  localparam logic [3:0] uir_idx_feature = 4'h8;
  localparam logic [3:0] uir_idx_enhanced = 4'h9;
  localparam logic [3:0] uir_idx_txc = 4'ha;
  localparam logic [3:0] uir_idx_rxc = 4'hb;
  localparam logic [3:0] uir_idx_xoff1 = 4'hc;
  localparam logic [3:0] uir_idx_xoff2 = 4'hd;
  localparam logic [3:0] uir_idx_xon1 = 4'he;
  localparam logic [3:0] uir_idx_xon2 = 4'hf;
  // Field positions
  localparam int uir_format_divisor_bit = 7;
  localparam int uir_modem_dtr_bit = 0;
  localparam int uir_modem_rts_bit = 1;
  localparam int uir_modem_loop_bit = 4;
  localparam int uir_modem_optical_bit = 6;
  localparam int uir_fraction_fast_bit = 4;
  localparam int uir_feature_invert_bit = 4;
  localparam int uir_enhanced_enable_bit = 4;
  // Reset values
  localparam logic [7:0] uir_reg_reset = 8'h00;
  // Last sampling tick of a bit and pulse widths in ticks
  localparam logic [3:0] uir_ticks_last = 4'hf;
  localparam logic [3:0] uir_pulse_std = 4'h3;
  localparam logic [3:0] uir_pulse_fast = 4'h4;

  typedef struct packed {
    logic [3:0] idx;
    logic write;
  } uir_req_type;
endpackage : uir_pkg

// ==== rtl/uir_channel.sv ====
/*
  One UART channel: AHB-Lite register slave, optical pulse codec, internal loopback.
  Assumes tick16_i pulses 16 times per bit; tx_bit_i/tx_busy_i come from a shift register outside,
  rx_bit_o feeds the receive shifter outside, and the status bytes are supplied by the channel core.
*/
`timescale 1ns/100ps
`default_nettype none
module uir_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Channel core
  input wire logic tick16_i,
  input wire logic tx_bit_i,
  input wire logic tx_busy_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [7:0] int_status_i,
  input wire logic [7:0] line_state_i,
  input wire logic [7:0] modem_state_i,
  input wire logic [7:0] tx_count_i,
  input wire logic [7:0] rx_count_i,
  input wire logic [7:0] flow_flags_i,
  output logic rx_bit_o,
  output logic rx_read_o,
  output logic tx_load_o,
  output logic queue_write_o,
  output logic [7:0] wdata_o,
  // Pins
  input wire logic optical_startup_pin_i,
  input wire logic rx_pin_i,
  input wire logic [3:0] modem_pins_n_i,
  output logic tx_pin_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic [3:0] modem_in_n_o
);
  import uir_pkg::*;

  logic [7:0] div_low, div_high, baud_fraction, int_enable, line_format, modem_control;
  logic [7:0] scratch_byte, feature_control, enhanced_function;
  logic [7:0] turn_delay, tx_trigger, rx_trigger, xoff1, xoff2, xon1, xon2;
  uir_req_type req;
  logic req_valid;
  logic startup_seen;

  // Address phase capture
  wire addr_ok = hsel_i && hready_i && htrans_i[1];
  wire [3:0] idx = haddr_i[5:2];
  wire dlab = line_format[uir_format_divisor_bit];
  wire wr = req_valid && req.write && enable_i;
  wire rd_take = addr_ok && !hwrite_i && enable_i;
  wire [7:0] wb = hwdata_i[7:0];
  wire ir_on = modem_control[uir_modem_optical_bit];
  wire loop_on = modem_control[uir_modem_loop_bit];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction : hit

  // Read mux
  logic [7:0] rmux;
  always_comb begin
    case (idx)
      uir_idx_data: rmux = dlab ? div_low : rx_data_i;
      uir_idx_int_enable: rmux = dlab ? div_high : int_enable;
      uir_idx_int_status: rmux = dlab ? baud_fraction : int_status_i;
      uir_idx_line_format: rmux = line_format;
      uir_idx_modem_control: rmux = modem_control;
      uir_idx_line_state: rmux = line_state_i;
      uir_idx_modem_state: rmux = modem_state_i;
      uir_idx_scratch: rmux = scratch_byte;
      uir_idx_feature: rmux = feature_control;
      uir_idx_enhanced: rmux = enhanced_function;
      uir_idx_txc: rmux = tx_count_i;
      uir_idx_rxc: rmux = rx_count_i;
      uir_idx_xoff1: rmux = flow_flags_i;
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_valid <= 1'b0;
      req <= '0;
      hrdata_o <= 32'h0000_0000;
      rx_read_o <= 1'b0;
    end else if (enable_i) begin
      req_valid <= addr_ok;
      req.idx <= idx;
      req.write <= hwrite_i;
      rx_read_o <= rd_take && hit(idx, uir_idx_data) && !dlab;
      if (rd_take) begin
        hrdata_o <= {24'h00_0000, rmux};
      end
    end
  end

  // Register writes in data phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {div_low, div_high, baud_fraction, int_enable} <= {4{uir_reg_reset}};
      {line_format, scratch_byte, feature_control, enhanced_function} <= {4{uir_reg_reset}};
      {turn_delay, tx_trigger, rx_trigger, xoff1, xoff2, xon1, xon2} <= {7{uir_reg_reset}};
      tx_load_o <= 1'b0;
      queue_write_o <= 1'b0;
      wdata_o <= 8'h00;
    end else if (enable_i) begin
      tx_load_o <= wr && hit(req.idx, uir_idx_data) && !dlab;
      queue_write_o <= wr && hit(req.idx, uir_idx_int_status) && !dlab;
      if (wr) begin
        wdata_o <= wb;
        case (req.idx)
          uir_idx_data: if (dlab) div_low <= wb;
          uir_idx_int_enable: if (dlab) div_high <= wb; else int_enable <= wb;
          uir_idx_int_status: if (dlab) baud_fraction <= wb;
          uir_idx_line_format: line_format <= wb;
          uir_idx_modem_state: if (enhanced_function[uir_enhanced_enable_bit]) turn_delay <= wb;
          uir_idx_scratch: scratch_byte <= wb;
          uir_idx_feature: feature_control <= wb;
          uir_idx_enhanced: enhanced_function <= wb;
          uir_idx_txc: tx_trigger <= wb;
          uir_idx_rxc: rx_trigger <= wb;
          uir_idx_xoff1: xoff1 <= wb;
          uir_idx_xoff2: xoff2 <= wb;
          uir_idx_xon1: xon1 <= wb;
          uir_idx_xon2: xon2 <= wb;
          default: ;
        endcase
      end
    end
  end

  // Modem control with startup pin caught after reset release
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      modem_control <= uir_reg_reset;
      startup_seen <= 1'b0;
    end else if (enable_i) begin
      if (!startup_seen) begin
        startup_seen <= 1'b1;
        modem_control[uir_modem_optical_bit] <= optical_startup_pin_i;
      end
      if (wr && hit(req.idx, uir_idx_modem_control)) begin
        modem_control <= wb;
      end
    end
  end

  // Encoder: pulse for zero bits, phase from sampling ticks
  logic [3:0] tx_phase;
  wire [3:0] pulse_len = baud_fraction[uir_fraction_fast_bit] ? uir_pulse_fast : uir_pulse_std;
  wire enc_out = !tx_bit_i && tx_busy_i && (tx_phase < pulse_len);
  wire tx_line = ir_on ? enc_out : tx_bit_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_phase <= 4'h0;
    end else if (enable_i) begin
      if (!tx_busy_i) begin
        tx_phase <= 4'h0;
      end else if (tick16_i) begin
        tx_phase <= tx_phase + 4'h1;
      end
    end
  end

  // Decoder: any pulse sample within a bit returns zero, except while tx_busy_i blanks the receiver
  wire rx_in = rx_pin_i ^ feature_control[uir_feature_invert_bit];
  logic [3:0] rx_phase;
  logic rx_seen, rx_active, dec_bit;
  wire rx_gate = rx_in && !tx_busy_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_phase <= 4'h0;
      rx_seen <= 1'b0;
      rx_active <= 1'b0;
      dec_bit <= 1'b1;
    end else if (enable_i) begin
      // Zero shows from the pulse to the end of its bit, so mid-bit sampling sees it
      if (!rx_active) begin
        if (rx_gate) begin
          rx_active <= 1'b1;
          rx_phase <= 4'h0;
          rx_seen <= 1'b1;
          dec_bit <= 1'b0;
        end
      end else if (tick16_i && rx_phase == uir_ticks_last) begin
        rx_phase <= 4'h0;
        rx_seen <= rx_gate;
        dec_bit <= !rx_gate;
        rx_active <= rx_seen || rx_gate;
      end else begin
        if (tick16_i) begin
          rx_phase <= rx_phase + 4'h1;
        end
        if (rx_gate) begin
          rx_seen <= 1'b1;
          dec_bit <= 1'b0;
        end
      end
    end
  end

  // Output pins and loopback routing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_pin_o <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      rx_bit_o <= 1'b1;
      modem_in_n_o <= 4'hf;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (enable_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (loop_on) begin
        tx_pin_o <= !ir_on;
        rts_n_o <= 1'b1;
        dtr_n_o <= 1'b1;
        rx_bit_o <= tx_bit_i;
        modem_in_n_o <= {~modem_control[uir_modem_rts_bit], ~modem_control[uir_modem_dtr_bit], 2'b11};
      end else begin
        tx_pin_o <= tx_line;
        rts_n_o <= ~modem_control[uir_modem_rts_bit];
        dtr_n_o <= ~modem_control[uir_modem_dtr_bit];
        rx_bit_o <= ir_on ? (tx_busy_i ? 1'b1 : dec_bit) : rx_pin_i;
        modem_in_n_o <= modem_pins_n_i;
      end
    end
  end
endmodule : uir_channel
`default_nettype wire

// ==== sim/uir_chk_sva.sv ====
/*
  Checker for uir_channel: bus answers, status reads and write strobes.
  Bound to every uir_channel; sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module uir_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bus and strobes
  input wire logic enable_i,
  input wire logic hsel_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic tx_load_o,
  input wire logic queue_write_o,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  // Core values
  input wire logic [7:0] line_state_i,
  input wire logic [7:0] modem_state_i,
  input wire logic [7:0] tx_count_i,
  input wire logic [7:0] flow_flags_i,
  input wire logic [7:0] wdata_o
);
  import uir_pkg::*;
  wire logic take = hsel_i & hready_i & htrans_i[1] & enable_i;
  wire logic wr_data = take & hwrite_i & (haddr_i[5:2] == uir_idx_data);
  wire logic wr_queue = take & hwrite_i & (haddr_i[5:2] == uir_idx_int_status);
  wire logic rd_none = take & ~hwrite_i & (haddr_i[5:2] > uir_idx_xoff1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rd(logic [3:0] i);
    take && !hwrite_i && haddr_i[5:2] == i;
  endsequence
  property p_bus; hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h0; endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  property p_lsr; s_rd(uir_idx_line_state) |=> hrdata_o[7:0] == $past(line_state_i); endproperty
  a_lsr: assert property (p_lsr) else $error("line state read wrong");
  property p_msr; s_rd(uir_idx_modem_state) |=> hrdata_o[7:0] == $past(modem_state_i); endproperty
  a_msr: assert property (p_msr) else $error("modem state read wrong");
  property p_cnt; s_rd(uir_idx_txc) |=> hrdata_o[7:0] == $past(tx_count_i); endproperty
  a_cnt: assert property (p_cnt) else $error("fill count read wrong");
  property p_flg; s_rd(uir_idx_xoff1) |=> hrdata_o[7:0] == $past(flow_flags_i); endproperty
  a_flg: assert property (p_flg) else $error("flow flags read wrong");
  property p_none; rd_none |=> hrdata_o == 32'h0; endproperty
  a_none: assert property (p_none) else $error("write-only read not zero");
  property p_load; tx_load_o |-> $past(wr_data, 2) && {24'h0, wdata_o} == ($past(hwdata_i) & 32'hff); endproperty
  a_load: assert property (p_load) else $error("transmit load wrong");
  property p_fcr; queue_write_o |-> $past(wr_queue, 2) && {24'h0, wdata_o} == ($past(hwdata_i) & 32'hff); endproperty
  a_fcr: assert property (p_fcr) else $error("queue control write wrong");
endmodule : uir_chk
bind uir_channel uir_chk chk_u (.*);
`default_nettype wire

// ==== sim/uir_partner.sv ====
/*
  Optical transceiver model: sends one framed byte as light pulses.
  Assumes tick16_i pulses 16 times per bit period.
*/
`timescale 1ns/100ps
`default_nettype none
module uir_partner (
  // Clock and bit tick
  input wire logic clk_i,
  input wire logic tick16_i,
  // Frame request
  input wire logic start_i,
  input wire logic invert_i,
  input wire logic [7:0] data_i,
  // Light seen by the channel
  output logic rx_o,
  output logic busy_o
);
  logic [9:0] frame = 10'h3ff;
  logic [7:0] ticks = 8'h0;
  initial busy_o = 1'b0;
  always @(posedge clk_i) begin
    if (start_i && !busy_o) begin
      frame <= {1'b1, data_i, 1'b0};
      ticks <= 8'h0;
      busy_o <= 1'b1;
    end else if (busy_o && tick16_i) begin
      ticks <= ticks + 8'h1;
      if (ticks[3:0] == 4'hf) frame <= frame >> 1;
      if (ticks == 8'h9f) busy_o <= 1'b0;
    end
  end
  // Pulse in the first 3 of 16 ticks of a zero bit, dark when idle; invert_i flips both levels
  assign rx_o = invert_i ^ (busy_o && !frame[0] && ticks[3:0] < 4'h3);
endmodule : uir_partner
`default_nettype wire

// ==== sim/uir_channel_tb_top.sv ====
/*
  Testbench for uir_channel: register bank, optical codec and loopback.
  Assumes uir_partner as the transceiver and uir_chk bound to the design.
*/
`timescale 1ns/100ps
`default_nettype none
module uir_channel_tb_top;
  import uir_pkg::*;
  int errors = 0;
  int checked = 0;
  int loads = 0;
  int reads = 0;
  int k;
  logic clk_i = 0, reset_i = 1, enable_i = 1, hsel_i = 0, hwrite_i = 0, tx_bit_i = 1, tx_busy_i = 0;
  logic optical_startup_pin_i = 1, pstart = 0, pinv = 0;
  logic [1:0] htrans_i = 0, tc = 0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 0, hwdata_i = 0;
  logic [7:0] cv = 8'h5a, q;
  logic [3:0] modem_pins_n_i = 4'ha, m;
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o, hresp_o, rx_bit_o, rx_read_o, tx_load_o, queue_write_o, tx_pin_o, rts_n_o, dtr_n_o;
  wire logic rx_pin_i, pbusy;
  wire logic [7:0] wdata_o;
  wire logic [3:0] modem_in_n_o;
  wire logic hready_i = hreadyout_o;
  wire logic tick16_i = tc == 2'h0;
  wire logic [7:0] rx_data_i = cv, int_status_i = cv ^ 8'h01, line_state_i = cv ^ 8'h02, modem_state_i = cv ^ 8'h03;
  wire logic [7:0] tx_count_i = cv ^ 8'h04, rx_count_i = cv ^ 8'h05, flow_flags_i = cv ^ 8'h06;
  localparam logic [3:0] rix [7] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'ha, 4'hb, 4'hc};
  uir_channel dut_u (.*);
  uir_partner part_u (.clk_i(clk_i), .tick16_i(tick16_i), .start_i(pstart), .invert_i(pinv),
    .data_i(cv), .rx_o(rx_pin_i), .busy_o(pbusy));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) tc <= tc + 2'h1;
  always @(posedge clk_i) if (tx_load_o === 1'b1) loads++;
  always @(posedge clk_i) if (rx_read_o === 1'b1) reads++;
  task automatic summarize;
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] a, input logic [31:0] b);
    checked++;
    if (a !== b) begin
      errors++;
      $display("Error %s expected %h seen %h", s, b, a);
    end
  endtask : chk
  task automatic wt;
    int n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; summarize; end
  endtask : wt
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    hsel_i <= 1'b1; htrans_i <= 2'h2; hwrite_i <= w; haddr_i <= {26'h0, i, 2'h0};
    wt;
    htrans_i <= 2'h0; hwdata_i <= {24'h0, d};
    wt;
    q = hrdata_o[7:0];
  endtask : bus
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h0);
    chk($sformatf("register %h", i), q, e);
  endtask : rd
  task automatic tx_pulse(input int e);
    int n = 0;
    int bad = 0;
    // Start the bit on a sampling tick, as the transmit shifter does
    do @(posedge clk_i); while (tick16_i !== 1'b1);
    pstart <= 1'b1; tx_busy_i <= 1'b1; tx_bit_i <= 1'b0;
    repeat (64) begin
      @(negedge clk_i);
      if (tx_pin_o === 1'b1) n++;
      if (rx_bit_o !== 1'b1) bad++;
    end
    @(posedge clk_i); pstart <= 1'b0; tx_busy_i <= 1'b0; tx_bit_i <= 1'b1;
    chk("pulse clocks", n, e);
    chk("blanked receive", bad, 0);
  endtask : tx_pulse
  task automatic rx_frame;
    logic [9:0] got;
    repeat (700) @(posedge clk_i);
    pstart <= 1'b1;
    @(posedge clk_i); pstart <= 1'b0;
    repeat (32) @(negedge clk_i);
    for (int j = 0; j < 10; j++) begin got[j] = rx_bit_o; repeat (64) @(negedge clk_i); end
    chk("decoded frame", got, {1'b1, cv, 1'b0});
    @(posedge clk_i);
  endtask : rx_frame
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(uir_idx_modem_control, 8'h40);
    rd(uir_idx_feature, uir_reg_reset);
    bus(1, uir_idx_modem_control, 8'h03); rd(uir_idx_modem_control, 8'h03);
    chk("request outputs", {rts_n_o, dtr_n_o, modem_in_n_o}, {2'b00, modem_pins_n_i});
    bus(1, uir_idx_scratch, 8'ha5); rd(uir_idx_scratch, 8'ha5);
    bus(1, uir_idx_int_enable, 8'h0f); bus(1, uir_idx_line_format, 8'h80);
    bus(1, uir_idx_data, 8'h12); bus(1, uir_idx_int_enable, 8'h34); bus(1, uir_idx_int_status, 8'h20);
    rd(uir_idx_data, 8'h12); rd(uir_idx_int_enable, 8'h34); rd(uir_idx_int_status, 8'h20);
    rd(uir_idx_line_format, 8'h80);
    bus(1, uir_idx_line_format, 8'h03); rd(uir_idx_int_enable, 8'h0f);
    bus(1, uir_idx_data, 8'h77); bus(1, uir_idx_int_status, 8'h01); bus(1, uir_idx_xon2, 8'h11);
    for (k = 0; k < 7; k++) begin
      cv <= cv + 8'h11;
      @(posedge clk_i);
      rd(rix[k], cv ^ 8'(k));
    end
    rd(uir_idx_xon2, 8'h00);
    chk("transmit loads", loads, 1);
    chk("receive reads", reads, 1);
    bus(1, uir_idx_modem_control, 8'h40);
    repeat (2) @(negedge clk_i);
    chk("optical idle", {tx_pin_o, rx_bit_o}, 2'b01);
    @(posedge clk_i);
    tx_pulse(12);
    rx_frame;
    pinv <= 1'b1; cv <= 8'h3c;
    bus(1, uir_idx_feature, 8'h10);
    rx_frame;
    bus(1, uir_idx_line_format, 8'h80); bus(1, uir_idx_int_status, 8'h10); bus(1, uir_idx_line_format, 8'h03);
    tx_pulse(16);
    bus(1, uir_idx_modem_control, 8'h13);
    tx_bit_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("loopback pins", {tx_pin_o, rts_n_o, dtr_n_o, rx_bit_o}, 4'b1110);
    m = modem_in_n_o;
    @(posedge clk_i); modem_pins_n_i <= ~modem_pins_n_i; tx_bit_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk("loopback inputs", {modem_in_n_o, rx_bit_o}, {m, 1'b1});
    @(posedge clk_i);
    rd(uir_idx_line_state, cv ^ 8'h02);
    summarize;
  end
endmodule : uir_channel_tb_top
`default_nettype wire
